/* shared/dca_consts.svh */
`ifndef DCA_CONSTS_SVH
`define DCA_CONSTS_SVH

// Pin widths of the command and address bus, bank-select width, and bank and mode register counts.
`define DCA_ADDR_W 14
`define DCA_BA_W 3
`define DCA_BANK_SEL_W 2
`define DCA_NBANK 4
`define DCA_NMODE 4

// Position of the auto-precharge and all-banks bit on the address bus.
`define DCA_AP_BIT 10

// Command codes as {RAS#, CAS#, WE#} while CS# is low.
`define DCA_CODE_LMR 3'h0
`define DCA_CODE_REF 3'h1
`define DCA_CODE_PRE 3'h2
`define DCA_CODE_ACT 3'h3
`define DCA_CODE_WR 3'h4
`define DCA_CODE_RD 3'h5
`define DCA_CODE_NOP 3'h7

// Reset levels of the driven pins.
`define DCA_RST_CKE 1'h0
`define DCA_RST_CS_N 1'h1
`define DCA_RST_ODT 1'h0

`endif

/* shared/dca_pkg.sv */
`default_nettype none
`include "dca_consts.svh"

package dca_pkg;

    // Commands carried by the control pins.
    typedef enum logic [2:0] {
        DCA_CMD_NOP,
        DCA_CMD_DESEL,
        DCA_CMD_ACT,
        DCA_CMD_RD,
        DCA_CMD_WR,
        DCA_CMD_PRE,
        DCA_CMD_LMR,
        DCA_CMD_REF
    } dca_cmd_t;

    // Power states of the input stage.
    typedef enum logic [1:0] {
        DCA_PWR_RUN,
        DCA_PWR_PPD,
        DCA_PWR_APD,
        DCA_PWR_SREF
    } dca_pwr_t;

endpackage

`default_nettype wire

/* shared/dca_if.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dca_consts.svh"

// Command, address and clock-enable pins between controller and memory.
interface dca_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic odt;
    logic [`DCA_BA_W-1:0] ba;
    logic [`DCA_ADDR_W-1:0] addr;

    modport ctrl (
        output cs_n,
        output ras_n,
        output cas_n,
        output we_n,
        output cke,
        output odt,
        output ba,
        output addr
    );

    modport dram (
        input cs_n,
        input ras_n,
        input cas_n,
        input we_n,
        input cke,
        input odt,
        input ba,
        input addr
    );
endinterface

`default_nettype wire

/* hw/dca_ddr2_ctl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dca_consts.svh"

// Controller end: turns user requests into registered pin levels.
module dca_ddr2_ctl (
    input wire logic clk,
    input wire logic sys_rst,
    dca_if.ctrl pins,
    input wire logic req_valid,
    input wire dca_pkg::dca_cmd_t req_cmd,
    input wire logic [`DCA_BA_W-1:0] req_bank,
    input wire logic [`DCA_ADDR_W-1:0] req_addr,
    input wire logic req_auto_pre,
    input wire logic req_all_banks,
    input wire logic req_cke,
    input wire logic req_odt,
    output logic req_ready
);

    ////////////////////////////////////////////////////////////////////////

    // Maps a command to {CS#, RAS#, CAS#, WE#}.
    function automatic logic [3:0] enc_cmd(input dca_pkg::dca_cmd_t c);
        logic [3:0] r;
        r = {1'h0, `DCA_CODE_NOP};
        unique case (c)
            dca_pkg::DCA_CMD_NOP: r = {1'h0, `DCA_CODE_NOP};
            dca_pkg::DCA_CMD_DESEL: r = {1'h1, `DCA_CODE_NOP};
            dca_pkg::DCA_CMD_ACT: r = {1'h0, `DCA_CODE_ACT};
            dca_pkg::DCA_CMD_RD: r = {1'h0, `DCA_CODE_RD};
            dca_pkg::DCA_CMD_WR: r = {1'h0, `DCA_CODE_WR};
            dca_pkg::DCA_CMD_PRE: r = {1'h0, `DCA_CODE_PRE};
            dca_pkg::DCA_CMD_LMR: r = {1'h0, `DCA_CODE_LMR};
            dca_pkg::DCA_CMD_REF: r = {1'h0, `DCA_CODE_REF};
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    logic cke_reg;
    logic odt_reg;
    logic [3:0] code_reg;
    logic [`DCA_BA_W-1:0] ba_reg;
    logic [`DCA_ADDR_W-1:0] addr_reg;
    wire take = req_valid && req_ready;
    wire [3:0] code_next = take ? enc_cmd(req_cmd) : enc_cmd(dca_pkg::DCA_CMD_NOP); // [R15] [R16]
    wire is_col = (req_cmd == dca_pkg::DCA_CMD_RD) || (req_cmd == dca_pkg::DCA_CMD_WR);
    wire is_pre = (req_cmd == dca_pkg::DCA_CMD_PRE);
    wire ap_bit = is_col ? req_auto_pre : (is_pre ? req_all_banks : req_addr[`DCA_AP_BIT]); // [R2] [R3]
    logic [`DCA_ADDR_W-1:0] addr_next;

    // Requests are taken only while the clock enable is already high.
    assign req_ready = cke_reg;

    // Address carries row, column, or op-code, with A10 overridden as needed.
    always_comb begin
        addr_next = req_addr; // [R1] [R4]
        addr_next[`DCA_AP_BIT] = ap_bit;
    end

    // Pins change only on the clock edge, so the far end sees settled levels.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cke_reg <= `DCA_RST_CKE;
            odt_reg <= `DCA_RST_ODT;
            code_reg <= {`DCA_RST_CS_N, `DCA_CODE_NOP};
            ba_reg <= '0;
            addr_reg <= '0;
        end else begin
            cke_reg <= req_cke; // [R10]
            odt_reg <= req_odt;
            code_reg <= code_next;
            if (take) begin
                ba_reg <= req_bank; // [R5] [R6]
                addr_reg <= addr_next;
            end
        end
    end

    // Pin drive.
    assign pins.cke = cke_reg;
    assign pins.odt = odt_reg;
    assign pins.cs_n = code_reg[3];
    assign pins.ras_n = code_reg[2];
    assign pins.cas_n = code_reg[1];
    assign pins.we_n = code_reg[0];
    assign pins.ba = ba_reg;
    assign pins.addr = addr_reg;

endmodule // dca_ddr2_ctl

`default_nettype wire

/* hw/dca_ddr2_dev.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dca_consts.svh"

// Contract
// R1: ACTIVATE takes address as row to open.
// R2: READ/WRITE take column; A10 requests auto-precharge.
// R3: PRECHARGE A10 low one bank, high all.
// R4: LOAD MODE address carries mode op-code.
// R5: BA[1:0] pick bank for bank commands.
// R6: BA picks mode register during LOAD MODE.
// R7: Sample inputs only on rising clock edge.
// R8: Registered CKE enables or disables internal clocking.
// R9: CKE low: idle gives PPD/SREF, open gives APD.
// R10: Power-down and self-refresh entry use sampled CKE.
// R11: Self-refresh exit seen from CKE without clock.
// R12: Power-down keeps only clock, CKE, ODT buffers.
// R13: Self refresh keeps only the CKE buffer.
// R14: Commands decoded only with CS# registered low.
// R15: RAS#, CAS#, WE#, CS# jointly set command.
// R16: Decoder follows the standard DDR2 truth table.
module dca_ddr2_dev (
    input wire logic clk,
    input wire logic sys_rst,
    dca_if.dram pins,
    output logic cmd_valid,
    output dca_pkg::dca_cmd_t cmd,
    output logic [`DCA_BANK_SEL_W-1:0] bank,
    output logic [`DCA_ADDR_W-1:0] row,
    output logic [`DCA_ADDR_W-1:0] col,
    output logic auto_pre,
    output logic pre_all,
    output logic [`DCA_BA_W-1:0] mode_sel,
    output logic [`DCA_ADDR_W-1:0] mode_opcode,
    output logic [`DCA_NMODE-1:0][`DCA_ADDR_W-1:0] mode_regs,
    output logic [`DCA_NBANK-1:0] bank_open,
    output logic clocking_en,
    output dca_pkg::dca_pwr_t pwr_state,
    output logic self_refresh,
    output logic cmd_buf_en,
    output logic clk_buf_en,
    output logic odt_buf_en,
    output logic odt_on
);

    ////////////////////////////////////////////////////////////////////////

    // Decodes {CS#, RAS#, CAS#, WE#} into a command.
    function automatic dca_pkg::dca_cmd_t dec_cmd(input logic [3:0] c);
        dca_pkg::dca_cmd_t r;
        r = dca_pkg::DCA_CMD_NOP;
        if (c[3]) begin
            r = dca_pkg::DCA_CMD_DESEL; // [R14]
        end else begin
            case (c[2:0])
                `DCA_CODE_LMR: r = dca_pkg::DCA_CMD_LMR;
                `DCA_CODE_REF: r = dca_pkg::DCA_CMD_REF;
                `DCA_CODE_PRE: r = dca_pkg::DCA_CMD_PRE;
                `DCA_CODE_ACT: r = dca_pkg::DCA_CMD_ACT;
                `DCA_CODE_WR: r = dca_pkg::DCA_CMD_WR;
                `DCA_CODE_RD: r = dca_pkg::DCA_CMD_RD;
                default: r = dca_pkg::DCA_CMD_NOP;
            endcase
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    dca_pkg::dca_pwr_t pwr_reg;
    dca_pkg::dca_pwr_t pwr_next;
    logic cke_reg;
    logic odt_reg;
    logic cmd_valid_reg;
    dca_pkg::dca_cmd_t cmd_reg;
    logic [`DCA_BANK_SEL_W-1:0] bank_reg;
    logic [`DCA_ADDR_W-1:0] row_reg;
    logic [`DCA_ADDR_W-1:0] col_reg;
    logic auto_pre_reg;
    logic pre_all_reg;
    logic [`DCA_BA_W-1:0] mode_sel_reg;
    logic [`DCA_ADDR_W-1:0] opcode_reg;
    logic [`DCA_ADDR_W-1:0] open_row_reg [`DCA_NBANK];
    logic [`DCA_ADDR_W-1:0] mode_mem_reg [`DCA_NMODE];
    logic [`DCA_NBANK-1:0] bank_open_reg;
    logic [`DCA_NBANK-1:0] bank_open_next;

    ////////////////////////////////////////////////////////////////////////

    // Input buffer enables follow the power state.
    wire run = (pwr_reg == dca_pkg::DCA_PWR_RUN);
    wire in_sref = (pwr_reg == dca_pkg::DCA_PWR_SREF);
    assign cmd_buf_en = run; // [R12] [R13]
    assign clk_buf_en = !in_sref; // [R13]
    assign odt_buf_en = !in_sref; // [R12] [R13]

    // Gated pin views: disabled receivers present an idle bus.
    wire [3:0] code_in = cmd_buf_en ? {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} : 4'hf;
    wire [`DCA_BA_W-1:0] ba_in = cmd_buf_en ? pins.ba : '0;
    wire [`DCA_ADDR_W-1:0] addr_in = cmd_buf_en ? pins.addr : '0;
    wire odt_in = odt_buf_en ? pins.odt : 1'h0;
    wire [`DCA_BANK_SEL_W-1:0] bsel = ba_in[`DCA_BANK_SEL_W-1:0]; // [R5]
    wire a10 = addr_in[`DCA_AP_BIT];

    // Command decode of the levels present at the rising edge.
    wire dca_pkg::dca_cmd_t cmd_now = dec_cmd(code_in); // [R15] [R16]
    wire all_idle = (bank_open_reg == '0);
    wire take = run && pins.cke; // [R8]
    wire is_act = take && (cmd_now == dca_pkg::DCA_CMD_ACT);
    wire is_col = take && ((cmd_now == dca_pkg::DCA_CMD_RD) || (cmd_now == dca_pkg::DCA_CMD_WR));
    wire is_pre = take && (cmd_now == dca_pkg::DCA_CMD_PRE);
    wire is_lmr = take && (cmd_now == dca_pkg::DCA_CMD_LMR);
    wire is_live = take && (cmd_now != dca_pkg::DCA_CMD_NOP) && (cmd_now != dca_pkg::DCA_CMD_DESEL);

    // Self-refresh entry is a REFRESH issued with CKE sampled low.
    wire sref_entry = run && !pins.cke && all_idle && (cmd_now == dca_pkg::DCA_CMD_REF); // [R10]

    // Exit from self refresh looks at the raw CKE level, with no edge needed.
    wire sref_exit = in_sref && pins.cke; // [R11]
    assign self_refresh = in_sref && !sref_exit; // [R11]

    ////////////////////////////////////////////////////////////////////////

    // Power state sequencing from the sampled clock enable.
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            dca_pkg::DCA_PWR_RUN: begin
                if (!pins.cke) begin
                    if (sref_entry) begin
                        pwr_next = dca_pkg::DCA_PWR_SREF; // [R9]
                    end else if (all_idle) begin
                        pwr_next = dca_pkg::DCA_PWR_PPD; // [R9]
                    end else begin
                        pwr_next = dca_pkg::DCA_PWR_APD; // [R9]
                    end
                end
            end
            dca_pkg::DCA_PWR_PPD, dca_pkg::DCA_PWR_APD: begin
                if (pins.cke) begin
                    pwr_next = dca_pkg::DCA_PWR_RUN; // [R10]
                end
            end
            dca_pkg::DCA_PWR_SREF: begin
                if (sref_exit) begin
                    pwr_next = dca_pkg::DCA_PWR_RUN;
                end
            end
        endcase
    end

    // Per-bank open flags: ACTIVATE opens, PRECHARGE or auto-precharge closes.
    for (genvar b = 0; b < `DCA_NBANK; b++) begin : g_bank
        wire hit = (int'(bsel) == b);
        wire close = (is_pre && (a10 || hit)) || (is_col && a10 && hit); // [R2] [R3]
        assign bank_open_next[b] = (is_act && hit) ? 1'h1 : (close ? 1'h0 : bank_open_reg[b]); // [R1]

        // Row held for the bank, used to form a full location on access.
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                open_row_reg[b] <= '0;
            end else if (is_act && hit) begin
                open_row_reg[b] <= addr_in; // [R1]
            end
        end
    end

    // Mode register shadow, written by LOAD MODE at the bank-selected slot.
    for (genvar m = 0; m < `DCA_NMODE; m++) begin : g_mode
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                mode_mem_reg[m] <= '0;
            end else if (is_lmr && (int'(ba_in) == m)) begin
                mode_mem_reg[m] <= addr_in; // [R4] [R6]
            end
        end
        assign mode_regs[m] = mode_mem_reg[m];
    end

    ////////////////////////////////////////////////////////////////////////

    // State and clock-enable capture, all on the rising edge only.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_reg <= dca_pkg::DCA_PWR_PPD;
            cke_reg <= `DCA_RST_CKE;
            odt_reg <= `DCA_RST_ODT;
            bank_open_reg <= '0;
        end else begin
            pwr_reg <= pwr_next;
            cke_reg <= pins.cke; // [R7] [R8]
            odt_reg <= odt_in;
            bank_open_reg <= bank_open_next;
        end
    end

    // Decoded command fields, held until the next live command.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_valid_reg <= 1'h0;
            cmd_reg <= dca_pkg::DCA_CMD_NOP;
            bank_reg <= '0;
            row_reg <= '0;
            col_reg <= '0;
            auto_pre_reg <= 1'h0;
            pre_all_reg <= 1'h0;
            mode_sel_reg <= '0;
            opcode_reg <= '0;
        end else begin
            cmd_valid_reg <= is_live; // [R7] [R14]
            if (is_live) begin
                cmd_reg <= cmd_now;
                bank_reg <= bsel; // [R5]
                auto_pre_reg <= is_col && a10; // [R2]
                pre_all_reg <= is_pre && a10; // [R3]
            end
            if (is_act) begin
                row_reg <= addr_in; // [R1]
            end
            if (is_col) begin
                row_reg <= open_row_reg[bsel];
                col_reg <= {addr_in[`DCA_ADDR_W-1:`DCA_AP_BIT+1], 1'h0, addr_in[`DCA_AP_BIT-1:0]}; // [R2]
            end
            if (is_lmr) begin
                mode_sel_reg <= ba_in; // [R6]
                opcode_reg <= addr_in; // [R4]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Outputs.
    assign cmd_valid = cmd_valid_reg;
    assign cmd = cmd_reg;
    assign bank = bank_reg;
    assign row = row_reg;
    assign col = col_reg;
    assign auto_pre = auto_pre_reg;
    assign pre_all = pre_all_reg;
    assign mode_sel = mode_sel_reg;
    assign mode_opcode = opcode_reg;
    assign bank_open = bank_open_reg;
    assign clocking_en = cke_reg; // [R8]
    assign pwr_state = pwr_reg;
    assign odt_on = odt_reg;

endmodule // dca_ddr2_dev

`default_nettype wire

/* verification/dca_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dca_consts.svh"

// Watches the pins and the decoded outputs of the memory end.
module dca_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [`DCA_BA_W-1:0] ba,
    input wire logic [`DCA_ADDR_W-1:0] addr,
    input wire logic cmd_valid,
    input wire dca_pkg::dca_cmd_t cmd,
    input wire logic [`DCA_BANK_SEL_W-1:0] bank,
    input wire logic [`DCA_ADDR_W-1:0] row,
    input wire logic [`DCA_ADDR_W-1:0] col,
    input wire logic auto_pre,
    input wire logic pre_all,
    input wire logic [`DCA_BA_W-1:0] mode_sel,
    input wire logic [`DCA_ADDR_W-1:0] mode_opcode,
    input wire logic [`DCA_NBANK-1:0] bank_open,
    input wire dca_pkg::dca_pwr_t pwr_state,
    input wire logic self_refresh,
    input wire logic cmd_buf_en,
    input wire logic clk_buf_en,
    input wire logic odt_buf_en
);
    logic [2:0] code;
    logic [1:0] bsel;
    logic live, ap_bit, ref_hit, in_run, in_pd, in_sref;

    // Works out what the memory end ought to take at each edge.
    assign code = {ras_n, cas_n, we_n};
    assign bsel = ba[1:0];
    assign ap_bit = addr[`DCA_AP_BIT];
    assign in_run = pwr_state == dca_pkg::DCA_PWR_RUN;
    assign in_pd = pwr_state == dca_pkg::DCA_PWR_PPD || pwr_state == dca_pkg::DCA_PWR_APD;
    assign in_sref = pwr_state == dca_pkg::DCA_PWR_SREF;
    assign ref_hit = !cs_n && code == `DCA_CODE_REF;
    assign live = in_run && cke && !cs_n && code != `DCA_CODE_NOP && code != 3'h6;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////
    a_live_cmd_pulse: assert property (live |=> cmd_valid)
        else $error("live command not decoded");
    a_ignored_cmd: assert property (cs_n || !cke |=> !cmd_valid)
        else $error("masked command decoded");
    a_act_row_bank: assert property (live && code == `DCA_CODE_ACT |=>
        cmd == dca_pkg::DCA_CMD_ACT && row == $past(addr) && bank == $past(bsel)) else $error("bad activate");
    a_rdwr_col_ap: assert property (live && (code == `DCA_CODE_RD || code == `DCA_CODE_WR) |=>
        auto_pre == $past(ap_bit) && col == ($past(addr) & 14'h3bff)) else $error("bad column");
    a_pre_scope: assert property (live && code == `DCA_CODE_PRE |=>
        cmd == dca_pkg::DCA_CMD_PRE && pre_all == $past(ap_bit)) else $error("bad precharge");
    a_lmr_opcode: assert property (live && code == `DCA_CODE_LMR |=>
        mode_opcode == $past(addr) && mode_sel == $past(ba)) else $error("bad mode load");
    a_idle_pd_entry: assert property (in_run && !cke && bank_open == 4'h0 |=>
        ($past(ref_hit) ? in_sref : pwr_state == dca_pkg::DCA_PWR_PPD)) else $error("bad idle entry");
    a_open_apd_entry: assert property (in_run && !cke && bank_open != 4'h0 |=>
        pwr_state == dca_pkg::DCA_PWR_APD) else $error("bad active entry");
    a_pd_exit: assert property (in_pd && cke |=> in_run)
        else $error("no power-down exit");
    a_pd_buffers: assert property (in_pd |-> !cmd_buf_en && clk_buf_en && odt_buf_en)
        else $error("bad power-down buffers");
    a_sref_buffers: assert property (in_sref |-> !cmd_buf_en && !clk_buf_en && !odt_buf_en)
        else $error("bad self refresh buffers");
    a_sref_exit: assert property (in_sref && cke |-> !self_refresh ##1 in_run)
        else $error("bad self refresh exit");

    // Main scenarios reached.
    c_read_ap: cover property (cmd_valid && cmd == dca_pkg::DCA_CMD_RD && auto_pre);
    c_sref: cover property (in_sref);
    c_apd: cover property (pwr_state == dca_pkg::DCA_PWR_APD);
endmodule // dca_properties

`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dca_consts.svh"

module tb_top;
    typedef struct packed {
        dca_pkg::dca_cmd_t cmd;
        logic [2:0] bank;
        logic [13:0] row;
        logic [13:0] col;
        logic ap;
    } dca_exp_t;
    localparam dca_pkg::dca_cmd_t ACT = dca_pkg::DCA_CMD_ACT;
    localparam dca_pkg::dca_cmd_t RD = dca_pkg::DCA_CMD_RD;
    localparam dca_pkg::dca_cmd_t WR = dca_pkg::DCA_CMD_WR;
    localparam dca_pkg::dca_cmd_t PRE = dca_pkg::DCA_CMD_PRE;
    localparam dca_pkg::dca_cmd_t LMR = dca_pkg::DCA_CMD_LMR;
    localparam dca_pkg::dca_cmd_t REF = dca_pkg::DCA_CMD_REF;
    logic clk, sys_rst, req_valid, req_auto_pre, req_all_banks, req_cke, req_odt, req_ready;
    dca_pkg::dca_cmd_t req_cmd, cmd;
    logic [2:0] req_bank, mode_sel, b;
    logic [13:0] req_addr, row, col, mode_opcode, a;
    logic [3:0][13:0] mode_regs, opc, open_row;
    logic [3:0] bank_open, open_mask;
    logic [1:0] bank;
    dca_pkg::dca_pwr_t pwr_state;
    logic cmd_valid, auto_pre, pre_all, clocking_en, self_refresh, cmd_buf_en, clk_buf_en, odt_buf_en, odt_on;
    dca_exp_t exp_q[$];
    dca_exp_t mon_e;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    dca_if dca_if_inst ();
    dca_ddr2_ctl dca_ddr2_ctl_inst (.clk(clk), .sys_rst(sys_rst), .pins(dca_if_inst), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_auto_pre(req_auto_pre),
        .req_all_banks(req_all_banks), .req_cke(req_cke), .req_odt(req_odt), .req_ready(req_ready));
    dca_ddr2_dev dca_ddr2_dev_inst (.clk(clk), .sys_rst(sys_rst), .pins(dca_if_inst), .cmd_valid(cmd_valid),
        .cmd(cmd), .bank(bank), .row(row), .col(col), .auto_pre(auto_pre), .pre_all(pre_all), .mode_sel(mode_sel),
        .mode_opcode(mode_opcode), .mode_regs(mode_regs), .bank_open(bank_open), .clocking_en(clocking_en),
        .pwr_state(pwr_state), .self_refresh(self_refresh), .cmd_buf_en(cmd_buf_en), .clk_buf_en(clk_buf_en),
        .odt_buf_en(odt_buf_en), .odt_on(odt_on));
    dca_properties dca_properties_inst (.clk(clk), .sys_rst(sys_rst), .cs_n(dca_if_inst.cs_n),
        .ras_n(dca_if_inst.ras_n), .cas_n(dca_if_inst.cas_n), .we_n(dca_if_inst.we_n), .cke(dca_if_inst.cke),
        .ba(dca_if_inst.ba), .addr(dca_if_inst.addr), .cmd_valid(cmd_valid), .cmd(cmd), .bank(bank), .row(row),
        .col(col), .auto_pre(auto_pre), .pre_all(pre_all), .mode_sel(mode_sel), .mode_opcode(mode_opcode),
        .bank_open(bank_open), .pwr_state(pwr_state), .self_refresh(self_refresh), .cmd_buf_en(cmd_buf_en),
        .clk_buf_en(clk_buf_en), .odt_buf_en(odt_buf_en));

    // Free-running clock.
    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Presents one request, notes what the memory end must report, waits until taken.
    task automatic issue(input dca_pkg::dca_cmd_t c, input logic [2:0] bk, input logic [13:0] ad,
                         input logic ap, input logic ck);
        dca_exp_t e;
        req_valid <= 1'b1;
        req_cmd <= c;
        req_bank <= bk;
        req_addr <= ad;
        req_auto_pre <= ap;
        req_all_banks <= ap;
        req_cke <= ck;
        e = '{c, bk, ad, ad & 14'h3bff, ap};
        if (c == RD || c == WR) e.row = open_row[bk[1:0]];
        if (ck && c != dca_pkg::DCA_CMD_NOP && c != dca_pkg::DCA_CMD_DESEL) exp_q.push_back(e);
        if (c == ACT) open_row[bk[1:0]] = ad;
        if (c == ACT) open_mask[bk[1:0]] = 1'b1;
        if (((c == RD || c == WR) && ap) || (c == PRE && !ap)) open_mask[bk[1:0]] = 1'b0;
        if (c == PRE && ap) open_mask = 4'h0;
        do @(posedge clk); while (req_ready !== 1'b1);
    endtask

    task automatic idle(input int n);
        req_valid <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    // Looks at the power outputs mid-cycle, when they are settled.
    task automatic check_pwr(input dca_pkg::dca_pwr_t s, input logic ce, input logic ke);
        @(negedge clk);
        check_val("pwr_state", s, pwr_state);
        check_val("cmd_buf_en", ce, cmd_buf_en);
        check_val("clk_buf_en", ke, clk_buf_en);
        check_val("odt_on", ke, odt_on);
        check_val("clocking_en", ce, clocking_en);
        check_val("req_ready", ce, req_ready);
        check_val("self_refresh", s == dca_pkg::DCA_PWR_SREF, self_refresh);
        @(posedge clk);
    endtask

    // Takes the oldest note off the queue whenever a command is reported.
    always @(negedge clk) begin
        if (cmd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_val("extra command", 16'h0, 16'h1);
            end else begin
                mon_e = exp_q.pop_front();
                check_val("cmd", mon_e.cmd, cmd);
                if (mon_e.cmd inside {ACT, RD, WR, PRE}) check_val("bank", mon_e.bank[1:0], bank);
                if (mon_e.cmd inside {ACT, RD, WR}) check_val("row", mon_e.row, row);
                if (mon_e.cmd inside {RD, WR}) check_val("col", mon_e.col, col);
                if (mon_e.cmd inside {RD, WR}) check_val("auto_pre", mon_e.ap, auto_pre);
                if (mon_e.cmd == PRE) check_val("pre_all", mon_e.ap, pre_all);
                if (mon_e.cmd == LMR) check_val("mode_opcode", mon_e.row, mode_opcode);
                if (mon_e.cmd == LMR) check_val("mode_sel", mon_e.bank, mode_sel);
            end
        end
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial begin
        clk = 0;
        sys_rst = 1;
        req_valid = 0;
        req_cmd = dca_pkg::DCA_CMD_NOP;
        req_bank = 0;
        req_addr = 0;
        req_auto_pre = 0;
        req_all_banks = 0;
        req_cke = 0;
        req_odt = 0;
        open_mask = 0;
        open_row = '0;
        void'($urandom(67281));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        req_cke <= 1'b1;
        req_odt <= 1'b1;
        idle(3);
        check_pwr(dca_pkg::DCA_PWR_RUN, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            opc[i] = 14'($urandom());
            issue(LMR, 3'(i), opc[i], 1'b0, 1'b1);
        end
        issue(LMR, 3'h5, 14'h3fff, 1'b0, 1'b1);
        idle(2);
        for (int i = 0; i < 4; i++) check_val("mode_regs", opc[i], mode_regs[i]);
        for (int i = 0; i < 4; i++) issue(ACT, 3'(i), 14'($urandom()), 1'b0, 1'b1);
        issue(RD, 3'h0, 14'($urandom()), 1'b0, 1'b1);
        issue(WR, 3'h1, 14'($urandom()), 1'b0, 1'b1);
        issue(RD, 3'h2, 14'($urandom()), 1'b1, 1'b1);
        issue(WR, 3'h3, 14'($urandom()), 1'b1, 1'b1);
        issue(dca_pkg::DCA_CMD_DESEL, 3'h1, 14'h1fff, 1'b0, 1'b1);
        issue(dca_pkg::DCA_CMD_NOP, 3'h1, 14'h0, 1'b0, 1'b1);
        issue(PRE, 3'h0, 14'h0, 1'b0, 1'b1);
        idle(2);
        check_val("bank_open", open_mask, bank_open);
        req_cke <= 1'b0;
        idle(3);
        check_pwr(dca_pkg::DCA_PWR_APD, 1'b0, 1'b1);
        req_cke <= 1'b1;
        idle(3);
        issue(PRE, 3'h2, 14'h0, 1'b1, 1'b1);
        idle(2);
        check_val("bank_open", open_mask, bank_open);
        req_cke <= 1'b0;
        idle(3);
        check_pwr(dca_pkg::DCA_PWR_PPD, 1'b0, 1'b1);
        req_cke <= 1'b1;
        idle(3);
        issue(REF, 3'h0, 14'h0, 1'b0, 1'b1);
        issue(REF, 3'h0, 14'h0, 1'b0, 1'b0);
        idle(3);
        check_pwr(dca_pkg::DCA_PWR_SREF, 1'b0, 1'b0);
        req_cke <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check_val("self_refresh", 1'b0, self_refresh);
        @(posedge clk);
        idle(2);
        check_pwr(dca_pkg::DCA_PWR_RUN, 1'b1, 1'b1);
        for (int k = 0; k < 24; k++) begin
            b = 3'($urandom() % 4);
            a = 14'($urandom());
            issue(ACT, b, a, 1'b0, 1'b1);
            issue(($urandom() % 2) ? RD : WR, b, 14'($urandom()), 1'($urandom()), 1'b1);
        end
        issue(PRE, 3'h0, 14'h0, 1'b1, 1'b1);
        idle(4);
        check_val("pending", 16'h0, 16'(exp_q.size()));
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
